// File: uedc_defines.vh
// uedc_defines.vh - offsets, field positions, codes and reset values of the endpoint control block
`ifndef UEDC_DEFINES_VH
`define UEDC_DEFINES_VH
// ****************************************
// register byte offsets
// ****************************************
`define UEDC_OFF_SELECT   8'h00
`define UEDC_OFF_CONTROL  8'h04
`define UEDC_OFF_TYPEDIR  8'h08
`define UEDC_OFF_SIZEBK   8'h0c
`define UEDC_OFF_STATUS0  8'h10
`define UEDC_OFF_STATUS1  8'h14
`define UEDC_OFF_INTFLAGS 8'h18
`define UEDC_OFF_INTEN    8'h1c
`define UEDC_OFF_SUMMARY  8'h20
// ****************************************
// field positions
// ****************************************
`define UEDC_B_STALL_REQUEST    5
`define UEDC_B_STALLCLR   4
`define UEDC_B_TGLRST     3
`define UEDC_B_ENABLE     0
`define UEDC_B_DIR        0
`define UEDC_B_MEMORY_ALLOCATE      1
`define UEDC_B_OVF        6
`define UEDC_B_UNF        5
`define UEDC_B_FIFO_CONTROL    7
`define UEDC_B_NAKIN      6
`define UEDC_B_NAKOUT     4
`define UEDC_B_RXSTP      3
`define UEDC_B_RXOUT      2
`define UEDC_B_STALLED    1
`define UEDC_B_TXIN       0
`define UEDC_B_FLERRE     7
// ****************************************
// codes and reset values
// ****************************************
`define UEDC_TYPE_CTRL    2'h0
`define UEDC_TYPE_ISO     2'h1
`define UEDC_TYPE_BULK    2'h2
`define UEDC_TYPE_INTR    2'h3
`define UEDC_SIZE_MAX_ALL 3'h3
`define UEDC_SIZE_MAX_EP1 3'h5
`define UEDC_EP_BIG       3'h1
`define UEDC_BASE_BYTES   12'h008
`define UEDC_MEM_BYTES    12'h340
`define UEDC_RST_BYTE     8'h00
`define UEDC_SEL_FORBID   3'h7
`endif

// File: uedc_endpoint_ctrl.v
// uedc_endpoint_ctrl.v - per-endpoint control, configuration, status and flag logic with an APB slave
//
// How it works
// - stall request set by software, cleared by SETUP
// - stall clear bit drops request, reads zero
// - toggle reset forces next toggle zero, self-clears
// - type field: control, iso, bulk, interrupt
// - direction bit: one IN, zero OUT/control
// - size codes 8..256 bytes, big only endpoint 1
// - bank field: single or double, rest reserved
// - allocate bit reserves or frees buffer memory
// - config valid judged when allocation requested
// - iso overflow/underflow flags, software clears only
// - toggle status: last OUT or next IN
// - busy bank count of occupied banks
// - control direction captured after each SETUP
// - current bank read-only, non-control endpoints
// - OUT packet sets fifo control and flag
// - IN bank free sets fifo control, ready
// - NAK IN / NAK OUT flags, software clears
// - access allowed from bank state, stall, error
// - SETUP flag, never on IN endpoints
// - kill bank discards last filled IN bank
// - stalled flag on STALL sent or iso OUT CRC
// - interrupt summary from enabled endpoint flags
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "uedc_defines.vh"
module uedc_endpoint_ctrl #(
   parameter EP_COUNT = 7
) (
   input  wire                  pclk,
   input  wire                  presetn,
   input  wire                  psel,
   input  wire                  penable,
   input  wire                  pwrite,
   input  wire [7:0]            paddr,
   input  wire [31:0]           pwdata,
   output wire                  pready,
   output reg  [31:0]           prdata,
   output wire                  pslverr,
   input  wire                  usb_reset,
   input  wire [2:0]            sie_ep,
   input  wire                  sie_setup,
   input  wire                  sie_setup_dir_in,
   input  wire                  sie_out,
   input  wire                  sie_rx_toggle,
   input  wire                  sie_in_sent,
   input  wire                  sie_nak_in,
   input  wire                  sie_nak_out,
   input  wire                  sie_stall_sent,
   input  wire                  sie_crc_err,
   input  wire                  sie_overflow,
   input  wire                  sie_underflow,
   output wire [EP_COUNT-1:0]   ep_enabled,
   output wire [EP_COUNT-1:0]   ep_stall,
   output wire [EP_COUNT-1:0]   ep_in_toggle,
   output wire [EP_COUNT-1:0]   ep_toggle_clr,
   output wire [EP_COUNT-1:0]   ep_bank_ready,
   output wire [EP_COUNT-1:0]   endpoint_interrupt_summary
);

   // ****************************************
   // helpers
   // ****************************************
   // buffer bytes that one endpoint takes for a size code and bank field
   function [11:0] ep_bytes;
      input [2:0] size;
      input [1:0] banks;
      begin
         ep_bytes = `UEDC_BASE_BYTES << size;
         if (banks[0])
            ep_bytes = {ep_bytes[10:0], 1'b0};
      end
   endfunction

   // ****************************************
   // apb slave
   // ****************************************
   reg  [2:0]              endpoint_select_reg;
   wire [EP_COUNT*8-1:0]   rd_ctl;
   wire [EP_COUNT*8-1:0]   rd_typ;
   wire [EP_COUNT*8-1:0]   rd_siz;
   wire [EP_COUNT*8-1:0]   rd_st0;
   wire [EP_COUNT*8-1:0]   rd_st1;
   wire [EP_COUNT*8-1:0]   rd_int;
   wire [EP_COUNT*8-1:0]   rd_ien;
   wire [EP_COUNT*12-1:0]  used_bytes;
   wire                    acc_wr;
   wire                    mapped;
   reg  [7:0]              rd_byte;
   integer                 k;

   // zero-wait slave: every access ends in its first access cycle
   assign pready  = 1'b1;
   assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= `UEDC_OFF_SUMMARY);
   assign pslverr = psel & penable & ~mapped;
   assign acc_wr  = psel & penable & pwrite & mapped;

   // endpoint selection, a forbidden value is kept out of the register
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         endpoint_select_reg <= 3'h0;
      end else if (acc_wr && paddr == `UEDC_OFF_SELECT && pwdata[2:0] != `UEDC_SEL_FORBID) begin
         endpoint_select_reg <= pwdata[2:0];
      end
   end

   // read mux for the selected endpoint
   always @* begin
      rd_byte = `UEDC_RST_BYTE;
      for (k = 0; k < EP_COUNT; k = k + 1) begin
         if (endpoint_select_reg == k[2:0]) begin
            case (paddr)
               `UEDC_OFF_CONTROL:  rd_byte = rd_ctl[k*8+:8];
               `UEDC_OFF_TYPEDIR:  rd_byte = rd_typ[k*8+:8];
               `UEDC_OFF_SIZEBK:   rd_byte = rd_siz[k*8+:8];
               `UEDC_OFF_STATUS0:  rd_byte = rd_st0[k*8+:8];
               `UEDC_OFF_STATUS1:  rd_byte = rd_st1[k*8+:8];
               `UEDC_OFF_INTFLAGS: rd_byte = rd_int[k*8+:8];
               `UEDC_OFF_INTEN:    rd_byte = rd_ien[k*8+:8];
               default:            rd_byte = rd_byte;
            endcase
         end
      end
      if (paddr == `UEDC_OFF_SELECT)
         rd_byte = {5'h00, endpoint_select_reg};
      if (paddr == `UEDC_OFF_SUMMARY)
         rd_byte = {{(8-EP_COUNT){1'b0}}, endpoint_interrupt_summary};
   end

   // read data is caught in the setup cycle so it comes from a flop in the access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // ****************************************
   // per-endpoint logic
   // ****************************************
   genvar i;
   generate
      for (i = 0; i < EP_COUNT; i = i + 1) begin : g_ep
         localparam [2:0] IDX = i;
         reg        en_reg;
         reg        stall_reg;
         reg        tclr_reg;
         reg [1:0]  type_reg;
         reg        dir_reg;
         reg [2:0]  size_reg;
         reg [1:0]  bk_reg;
         reg        memory_allocate_reg;
         reg        config_valid_reg;
         reg        ovf_reg;
         reg        unf_reg;
         reg        dtin_reg;
         reg        dtout_reg;
         reg        cdir_reg;
         reg        cur_reg;
         reg [1:0]  busy_reg;
         reg        fifo_reg;
         reg        nakin_reg;
         reg        nakout_reg;
         reg        stp_reg;
         reg        rxo_reg;
         reg        stl_reg;
         reg        txi_reg;
         reg        kill_reg;
         reg [7:0]  ien_reg;
         reg [11:0] others;
         integer    j;
         wire       hit = (sie_ep == IDX);
         wire       sel = (endpoint_select_reg == IDX);
         wire       w_ctl = acc_wr & sel & (paddr == `UEDC_OFF_CONTROL);
         wire       w_typ = acc_wr & sel & (paddr == `UEDC_OFF_TYPEDIR);
         wire       w_siz = acc_wr & sel & (paddr == `UEDC_OFF_SIZEBK);
         wire       w_st0 = acc_wr & sel & (paddr == `UEDC_OFF_STATUS0);
         wire       w_int = acc_wr & sel & (paddr == `UEDC_OFF_INTFLAGS);
         wire       w_ien = acc_wr & sel & (paddr == `UEDC_OFF_INTEN);
         wire       is_ctl = (type_reg == `UEDC_TYPE_CTRL);
         wire       is_iso = (type_reg == `UEDC_TYPE_ISO);
         wire       is_in = dir_reg & ~is_ctl;
         wire [1:0] nbk = bk_reg[0] ? 2'h2 : 2'h1;
         wire       tgl_rst = w_ctl & pwdata[`UEDC_B_TGLRST];
         wire       e_rx = hit & (sie_out | sie_setup) & ~is_in & (busy_reg < nbk);
         wire       rel = w_int & ~pwdata[`UEDC_B_FIFO_CONTROL] & fifo_reg;
         wire       kill = w_int & pwdata[`UEDC_B_RXOUT] & is_in & (busy_reg != 2'h0);
         wire       in_dec = is_in & ((hit & sie_in_sent) | kill) & (busy_reg != 2'h0);
         wire       inc = is_in ? (rel & (busy_reg < nbk)) : e_rx;
         wire       dec = is_in ? in_dec : (rel & (busy_reg != 2'h0));
         wire [1:0] busy_n = busy_reg + {1'b0, inc} - {1'b0, dec};
         wire       fifo_n = is_in ? (busy_n < nbk) : (busy_n != 2'h0);
         wire       size_ok = (size_reg <= `UEDC_SIZE_MAX_ALL) ||
                              (IDX == `UEDC_EP_BIG && size_reg <= `UEDC_SIZE_MAX_EP1);
         wire [11:0] mine = ep_bytes(pwdata[6:4], pwdata[3:2]);
         wire       fit_size = (pwdata[6:4] <= `UEDC_SIZE_MAX_ALL) ||
                               (IDX == `UEDC_EP_BIG && pwdata[6:4] <= `UEDC_SIZE_MAX_EP1);
         wire       fit = fit_size & ~pwdata[3] & (others + mine <= `UEDC_MEM_BYTES);
         wire       err = ~config_valid_reg | ovf_reg | unf_reg;
         wire       access_allowed = ~stall_reg & ~err & (is_in ? (busy_reg < nbk) : (busy_reg != 2'h0));
         wire [6:0] srcs = {ovf_reg | unf_reg, nakin_reg, nakout_reg, stp_reg, rxo_reg, stl_reg, txi_reg};
         wire [6:0] ens = {ien_reg[7:6], ien_reg[4:0]};

         // memory already held by the other endpoints
         always @* begin
            others = 12'h000;
            for (j = 0; j < EP_COUNT; j = j + 1) begin
               if (j != i)
                  others = others + used_bytes[j*12+:12];
            end
         end

         // a usb bus reset returns the endpoint to its power-up state
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               en_reg <= 1'b0; stall_reg <= 1'b0; tclr_reg <= 1'b0;
               type_reg <= 2'h0; dir_reg <= 1'b0; size_reg <= 3'h0; bk_reg <= 2'h0;
               memory_allocate_reg <= 1'b0; config_valid_reg <= 1'b0; ovf_reg <= 1'b0; unf_reg <= 1'b0;
               dtin_reg <= 1'b0; dtout_reg <= 1'b0; cdir_reg <= 1'b0; cur_reg <= 1'b0;
               busy_reg <= 2'h0; fifo_reg <= 1'b0; nakin_reg <= 1'b0; nakout_reg <= 1'b0;
               stp_reg <= 1'b0; rxo_reg <= 1'b0; stl_reg <= 1'b0; txi_reg <= 1'b0;
               kill_reg <= 1'b0; ien_reg <= 8'h00;
            end else if (usb_reset) begin
               en_reg <= 1'b0; stall_reg <= 1'b0; tclr_reg <= 1'b0;
               type_reg <= 2'h0; dir_reg <= 1'b0; size_reg <= 3'h0; bk_reg <= 2'h0;
               memory_allocate_reg <= 1'b0; config_valid_reg <= 1'b0; ovf_reg <= 1'b0; unf_reg <= 1'b0;
               dtin_reg <= 1'b0; dtout_reg <= 1'b0; cdir_reg <= 1'b0; cur_reg <= 1'b0;
               busy_reg <= 2'h0; fifo_reg <= 1'b0; nakin_reg <= 1'b0; nakout_reg <= 1'b0;
               stp_reg <= 1'b0; rxo_reg <= 1'b0; stl_reg <= 1'b0; txi_reg <= 1'b0;
               kill_reg <= 1'b0; ien_reg <= 8'h00;
            end else begin
               // control register
               if (w_ctl)
                  en_reg <= pwdata[`UEDC_B_ENABLE];
               if (hit & sie_setup)
                  stall_reg <= 1'b0;
               else if (w_ctl & pwdata[`UEDC_B_STALLCLR])
                  stall_reg <= 1'b0;
               else if (w_ctl & pwdata[`UEDC_B_STALL_REQUEST])
                  stall_reg <= 1'b1;
               tclr_reg <= tgl_rst;
               // configuration
               if (w_typ) begin
                  type_reg <= pwdata[7:6];
                  dir_reg  <= pwdata[`UEDC_B_DIR];
               end
               if (w_siz) begin
                  size_reg  <= pwdata[6:4];
                  bk_reg    <= pwdata[3:2];
                  memory_allocate_reg <= pwdata[`UEDC_B_MEMORY_ALLOCATE];
                  if (pwdata[`UEDC_B_MEMORY_ALLOCATE])
                     config_valid_reg <= fit;
               end
               // iso flow flags: hardware set beats a software clear
               ovf_reg <= (hit & sie_overflow & is_iso) |
                          (ovf_reg & ~(w_st0 & ~pwdata[`UEDC_B_OVF]));
               unf_reg <= (hit & sie_underflow & is_iso) |
                          (unf_reg & ~(w_st0 & ~pwdata[`UEDC_B_UNF]));
               // toggle tracking
               if (tgl_rst)
                  dtin_reg <= 1'b0;
               else if (hit & sie_in_sent & is_in)
                  dtin_reg <= ~dtin_reg;
               if (e_rx)
                  dtout_reg <= sie_rx_toggle;
               if (hit & sie_setup)
                  cdir_reg <= sie_setup_dir_in;
               // bank bookkeeping
               busy_reg <= busy_n;
               fifo_reg <= fifo_n;
               if (bk_reg[0] & (rel | (is_in & kill)))
                  cur_reg <= ~cur_reg;
               kill_reg <= kill;
               // event flags, set wins over the software clear
               txi_reg <= (is_in & fifo_n & (rel | ~fifo_reg)) |
                          (txi_reg & is_in & ~(w_int & ~pwdata[`UEDC_B_TXIN]));
               rxo_reg <= (e_rx & hit & sie_out) |
                          (rxo_reg & ~(w_int & ~is_in & ~pwdata[`UEDC_B_RXOUT]));
               stp_reg <= (e_rx & hit & sie_setup) |
                          (stp_reg & ~is_in & ~(w_int & ~pwdata[`UEDC_B_RXSTP]));
               nakin_reg <= (hit & sie_nak_in) |
                            (nakin_reg & ~(w_int & ~pwdata[`UEDC_B_NAKIN]));
               nakout_reg <= (hit & sie_nak_out) |
                             (nakout_reg & ~(w_int & ~pwdata[`UEDC_B_NAKOUT]));
               stl_reg <= (hit & sie_stall_sent) | (hit & sie_crc_err & is_iso & ~is_in) |
                          (stl_reg & ~(w_int & ~pwdata[`UEDC_B_STALLED]));
               if (w_ien)
                  ien_reg <= pwdata[7:0] & 8'hdf;
            end
         end

         // register images and engine-facing state
         assign rd_ctl[i*8+:8] = {2'h0, stall_reg, 4'h0, en_reg};
         assign rd_typ[i*8+:8] = {type_reg, 5'h00, dir_reg};
         assign rd_siz[i*8+:8] = {1'b0, size_reg, bk_reg, memory_allocate_reg, 1'b0};
         assign rd_st0[i*8+:8] = {config_valid_reg, ovf_reg, unf_reg, 1'b0,
                                  1'b0, is_in ? dtin_reg : dtout_reg, busy_reg};
         assign rd_st1[i*8+:8] = {5'h00, cdir_reg, 1'b0, cur_reg & ~is_ctl};
         assign rd_int[i*8+:8] = {fifo_reg, nakin_reg, access_allowed, nakout_reg, stp_reg & ~is_in,
                                  is_in ? kill_reg : rxo_reg, stl_reg, txi_reg & is_in};
         assign rd_ien[i*8+:8] = ien_reg;
         assign used_bytes[i*12+:12] = (memory_allocate_reg & config_valid_reg & size_ok) ?
                                       ep_bytes(size_reg, bk_reg) : 12'h000;
         assign endpoint_interrupt_summary[i] = |(srcs & ens);
         assign ep_enabled[i]    = en_reg & memory_allocate_reg & config_valid_reg;
         assign ep_stall[i]      = stall_reg;
         assign ep_in_toggle[i]  = dtin_reg;
         assign ep_toggle_clr[i] = tclr_reg;
         assign ep_bank_ready[i] = is_in ? (busy_reg != 2'h0) : (busy_reg < nbk);
      end
   endgenerate

endmodule // uedc_endpoint_ctrl
`default_nettype wire

// File: uedc_endpoint_ctrl_asserts.sv
// assertion checker for the endpoint control block
`timescale 1ns/1ps
`default_nettype none
`include "uedc_defines.vh"
module uedc_endpoint_ctrl_asserts #(
   parameter EP_COUNT = 7
) (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [7:0]          paddr,
   input wire logic [31:0]         pwdata,
   input wire logic                pslverr,
   input wire logic                usb_reset,
   input wire logic [2:0]          sie_ep,
   input wire logic                sie_setup,
   input wire logic [EP_COUNT-1:0] ep_enabled,
   input wire logic [EP_COUNT-1:0] ep_stall,
   input wire logic [EP_COUNT-1:0] ep_toggle_clr,
   input wire logic [EP_COUNT-1:0] endpoint_interrupt_summary
);
   // ****************************************
   // selected endpoint tracking
   // ****************************************
   logic [2:0] sel_reg;
   wire        wr_any = psel & penable & pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // the forbidden select value is dropped, so the shadow copy drops it too
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sel_reg <= 3'h0;
      else if (wr_any && paddr == `UEDC_OFF_SELECT && pwdata[2:0] != `UEDC_SEL_FORBID)
         sel_reg <= pwdata[2:0];
   end
   // ****************************************
   // properties
   // ****************************************
   // a write with no bus reset or setup competing in the same cycle
   sequence s_wr(logic [7:0] a);
      wr_any && paddr == a && !usb_reset && !sie_setup;
   endsequence
   sequence s_pulse;
      ep_toggle_clr[sel_reg] ##1 !ep_toggle_clr[sel_reg];
   endsequence
   a_stall_set:
      assert property (s_wr(`UEDC_OFF_CONTROL) ##0 pwdata[5] |=> ep_stall[sel_reg]) else $error("stall not set");
   a_stall_setup:
      assert property (sie_setup && !wr_any && !usb_reset && sie_ep != 3'h7 |=> !ep_stall[$past(sie_ep)])
         else $error("setup left stall set");
   a_stall_clear:
      assert property (s_wr(`UEDC_OFF_CONTROL) ##0 (pwdata[4] && !pwdata[5]) |=> !ep_stall[sel_reg])
         else $error("stall clear ignored");
   a_toggle_pulse:
      assert property (s_wr(`UEDC_OFF_CONTROL) ##0 pwdata[3] |=> s_pulse) else $error("toggle clear not one pulse");
   a_disable_ep:
      assert property (s_wr(`UEDC_OFF_CONTROL) ##0 !pwdata[0] |=> !ep_enabled[sel_reg]) else $error("still enabled");
   a_free_mem:
      assert property (s_wr(`UEDC_OFF_SIZEBK) ##0 !pwdata[1] |=> !ep_enabled[sel_reg]) else $error("memory not freed");
   a_bad_size:
      assert property (s_wr(`UEDC_OFF_SIZEBK) ##0 (pwdata[3] || pwdata[6:4] > `UEDC_SIZE_MAX_EP1
         || (pwdata[6:4] > `UEDC_SIZE_MAX_ALL && sel_reg != `UEDC_EP_BIG)) |=> !ep_enabled[sel_reg])
         else $error("bad config accepted");
   a_mask_all:
      assert property (s_wr(`UEDC_OFF_INTEN) ##0 pwdata[7:0] == 8'h00 |=> !endpoint_interrupt_summary[sel_reg])
         else $error("summary with no enable");
   a_unmapped_err:
      assert property (psel && penable && (paddr[1:0] != 2'h0 || paddr > `UEDC_OFF_SUMMARY) |-> pslverr)
         else $error("no error on unmapped address");
endmodule // uedc_endpoint_ctrl_asserts
`default_nettype wire

// File: uedc_sie_model.sv
// usb engine stand-in: one-cycle event pulses toward the endpoint block
`timescale 1ns/1ps
`default_nettype none
module uedc_sie_model (
   input  wire logic       pclk,
   output wire logic [2:0] sie_ep,
   output wire logic       sie_setup,
   output wire logic       sie_setup_dir_in,
   output wire logic       sie_out,
   output wire logic       sie_rx_toggle,
   output wire logic       sie_in_sent,
   output wire logic       sie_nak_in,
   output wire logic       sie_nak_out,
   output wire logic       sie_stall_sent,
   output wire logic       sie_crc_err,
   output wire logic       sie_overflow,
   output wire logic       sie_underflow
);
   logic [8:0] ev_reg = 9'h000;
   logic [2:0] ep_reg = 3'h0;
   logic       qual_reg = 1'b0;
   // one packet per call; the host only fills a bank the device has freed
   assign {sie_underflow, sie_overflow, sie_crc_err, sie_stall_sent, sie_nak_out, sie_nak_in, sie_in_sent, sie_out,
           sie_setup} = ev_reg;
   assign sie_ep = ep_reg;
   assign sie_setup_dir_in = qual_reg;
   assign sie_rx_toggle = qual_reg;
   // qualifiers flip after the pulse so a stale value never looks valid
   task automatic pulse(input int kind, input logic [2:0] ep, input logic q);
      ev_reg <= 9'h001 << kind;
      ep_reg <= ep;
      qual_reg <= q;
      @(posedge pclk);
      ev_reg <= 9'h000;
      ep_reg <= ~ep;
      qual_reg <= ~q;
      @(posedge pclk);
   endtask
endmodule // uedc_sie_model
`default_nettype wire

// File: uedc_endpoint_ctrl_tb.sv
// self-checking bench for the endpoint control block
`timescale 1ns/1ps
`default_nettype none
`include "uedc_defines.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module uedc_endpoint_ctrl_tb;
   localparam logic [7:0] SL = `UEDC_OFF_SELECT, CT = `UEDC_OFF_CONTROL, TD = `UEDC_OFF_TYPEDIR;
   localparam logic [7:0] SB = `UEDC_OFF_SIZEBK, S0 = `UEDC_OFF_STATUS0, S1 = `UEDC_OFF_STATUS1;
   localparam logic [7:0] FL = `UEDC_OFF_INTFLAGS, IE = `UEDC_OFF_INTEN, SM = `UEDC_OFF_SUMMARY;
   localparam logic [7:0] BAD_CFG[4] = '{8'h52, 8'h62, 8'h0a, 8'h02};
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, usb_reset = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd_data;
   logic        err_seen;
   wire logic   pready, pslverr, sie_setup, sie_setup_dir_in, sie_out, sie_rx_toggle, sie_in_sent;
   wire logic   sie_nak_in, sie_nak_out, sie_stall_sent, sie_crc_err, sie_overflow, sie_underflow;
   wire logic [2:0]  sie_ep;
   wire logic [31:0] prdata;
   wire logic [6:0]  ep_enabled, ep_stall, ep_in_toggle, ep_toggle_clr, ep_bank_ready, ep_int;
   int fail_count = 0, n_checks = 0, cycles = 0, i;
   always #4 pclk = ~pclk;
   uedc_endpoint_ctrl #(.EP_COUNT(7)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .usb_reset(usb_reset), .sie_ep(sie_ep), .sie_setup(sie_setup), .sie_setup_dir_in(sie_setup_dir_in),
      .sie_out(sie_out), .sie_rx_toggle(sie_rx_toggle), .sie_in_sent(sie_in_sent), .sie_nak_in(sie_nak_in),
      .sie_nak_out(sie_nak_out), .sie_stall_sent(sie_stall_sent), .sie_crc_err(sie_crc_err),
      .sie_overflow(sie_overflow), .sie_underflow(sie_underflow), .ep_enabled(ep_enabled), .ep_stall(ep_stall),
      .ep_in_toggle(ep_in_toggle), .ep_toggle_clr(ep_toggle_clr), .ep_bank_ready(ep_bank_ready),
      .endpoint_interrupt_summary(ep_int));
   uedc_sie_model u_sie (.pclk(pclk), .sie_ep(sie_ep), .sie_setup(sie_setup), .sie_setup_dir_in(sie_setup_dir_in),
      .sie_out(sie_out), .sie_rx_toggle(sie_rx_toggle), .sie_in_sent(sie_in_sent), .sie_nak_in(sie_nak_in),
      .sie_nak_out(sie_nak_out), .sie_stall_sent(sie_stall_sent), .sie_crc_err(sie_crc_err),
      .sie_overflow(sie_overflow), .sie_underflow(sie_underflow));
   // ****************************************
   // bus tasks and closing report
   // ****************************************
   // one apb transfer with an idle cycle after it, so no signal is assigned twice in a step
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      k = 0;
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, 24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k == 20) fail_count++;
      rd_data = prdata;
      err_seen = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      `CHK($sformatf("reg %h", a), {24'h0, e}, rd_data & {24'hffffff, m})
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // hang guard, far above the few hundred cycles the sequence needs
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         summarize();
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rc(S0, 8'hff, 8'h00);
      rc(S1, 8'hff, 8'h00);
      rc(FL, 8'hff, 8'h00);
      apb(1'b1, SL, 8'h01);
      apb(1'b1, SL, 8'h07);
      rc(SL, 8'hff, 8'h01);
      // endpoint 1: bulk in, 256 bytes, two banks
      apb(1'b1, CT, 8'h01);
      apb(1'b1, TD, 8'h81);
      apb(1'b1, SB, 8'h56);
      rc(S0, 8'h83, 8'h80);
      `CHK("enabled 1", 1'b1, ep_enabled[1])
      rc(FL, 8'h81, 8'h81);
      apb(1'b1, FL, 8'h7b);
      rc(S0, 8'h07, 8'h01);
      rc(S1, 8'h01, 8'h01);
      `CHK("bank ready 1", 1'b1, ep_bank_ready[1])
      apb(1'b1, FL, 8'h7b);
      rc(S0, 8'h03, 8'h02);
      rc(FL, 8'ha0, 8'h00);
      apb(1'b1, FL, 8'hff);
      rc(S0, 8'h03, 8'h01);
      rc(FL, 8'h04, 8'h00);
      u_sie.pulse(2, 3'h1, 1'b0);
      rc(S0, 8'h07, 8'h04);
      apb(1'b1, CT, 8'h09);
      rc(S0, 8'h04, 8'h00);
      rc(CT, 8'h08, 8'h00);
      `CHK("in toggle 1", 1'b0, ep_in_toggle[1])
      for (i = 3; i < 6; i++) u_sie.pulse(i, 3'h1, 1'b0);
      rc(FL, 8'h52, 8'h52);
      apb(1'b1, IE, 8'h40);
      rc(SM, 8'h7f, 8'h02);
      apb(1'b1, FL, 8'hbb);
      rc(FL, 8'h52, 8'h12);
      rc(SM, 8'h7f, 8'h00);
      apb(1'b1, IE, 8'h00);
      // endpoints 2..4 at 64 bytes, two banks: the third no longer fits
      for (i = 2; i < 5; i++) begin
         apb(1'b1, SL, 8'(i));
         apb(1'b1, CT, 8'h01);
         apb(1'b1, TD, 8'h80);
         apb(1'b1, SB, 8'h36);
         rc(S0, 8'h80, (i < 4) ? 8'h80 : 8'h00);
      end
      for (i = 0; i < 4; i++) begin
         apb(1'b1, SB, BAD_CFG[i]);
         rc(S0, 8'h80, (i == 3) ? 8'h80 : 8'h00);
         apb(1'b1, TD, {2'(i), 6'h00});
         rc(TD, 8'hff, {2'(i), 6'h00});
      end
      apb(1'b1, SB, 8'h00);
      `CHK("enabled 4", 1'b0, ep_enabled[4])
      apb(1'b1, CT, 8'h00);
      // endpoint 0: stall, then setup in both directions
      apb(1'b1, SL, 8'h00);
      apb(1'b1, CT, 8'h21);
      apb(1'b1, CT, 8'h01);
      `CHK("stall 0", 1'b1, ep_stall[0])
      u_sie.pulse(0, 3'h0, 1'b1);
      `CHK("stall 0", 1'b0, ep_stall[0])
      rc(S1, 8'h04, 8'h04);
      rc(FL, 8'h8c, 8'h88);
      apb(1'b1, FL, 8'h77);
      rc(FL, 8'h88, 8'h00);
      u_sie.pulse(0, 3'h0, 1'b0);
      rc(S1, 8'h04, 8'h00);
      apb(1'b1, CT, 8'h21);
      apb(1'b1, CT, 8'h11);
      `CHK("stall 0", 1'b0, ep_stall[0])
      rc(CT, 8'h30, 8'h00);
      // endpoint 2 out packet, then endpoint 3 as isochronous
      apb(1'b1, SL, 8'h02);
      u_sie.pulse(1, 3'h2, 1'b1);
      rc(FL, 8'ha4, 8'ha4);
      rc(S0, 8'h07, 8'h05);
      apb(1'b1, FL, 8'h7b);
      rc(S0, 8'h03, 8'h00);
      apb(1'b1, SL, 8'h03);
      apb(1'b1, TD, 8'h40);
      for (i = 6; i < 9; i++) u_sie.pulse(i, 3'h3, 1'b0);
      rc(FL, 8'h02, 8'h02);
      apb(1'b1, S0, 8'hff);
      rc(S0, 8'h60, 8'h60);
      apb(1'b1, S0, 8'h00);
      rc(S0, 8'h60, 8'h00);
      apb(1'b0, 8'h24, 8'h00);
      `CHK("slverr", 1'b1, err_seen)
      `CHK("unmapped", 32'h0, rd_data)
      usb_reset <= 1'b1;
      @(posedge pclk);
      usb_reset <= 1'b0;
      @(posedge pclk);
      `CHK("enabled", 7'h00, ep_enabled)
      rc(SL, 8'hff, 8'h03);
      summarize();
   end
endmodule // uedc_endpoint_ctrl_tb
bind uedc_endpoint_ctrl uedc_endpoint_ctrl_asserts #(.EP_COUNT(EP_COUNT)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
   .usb_reset(usb_reset), .sie_ep(sie_ep), .sie_setup(sie_setup), .ep_enabled(ep_enabled), .ep_stall(ep_stall),
   .ep_toggle_clr(ep_toggle_clr), .endpoint_interrupt_summary(endpoint_interrupt_summary));
`default_nettype wire
